/* logic/stc_pkg.sv */
// package: register map, control field layout and reset values of the 16-bit timer/counter
package stc_pkg;

    // apb byte addresses of the registers
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_CNT_LO  = 12'h004;
    localparam logic [11:0] ADDR_CNT_HI  = 12'h008;
    localparam logic [11:0] ADDR_IRQ     = 12'h00C;
    localparam logic [11:0] ADDR_CMP_LO  = 12'h010;
    localparam logic [11:0] ADDR_CMP_HI  = 12'h014;
    localparam logic [11:0] ADDR_CMP_CFG = 12'h018;

    // control register field positions
    localparam int CTL_EN    = 0;
    localparam int CTL_SRC   = 1;
    localparam int CTL_NSYNC = 2;
    localparam int CTL_OSCEN = 3;
    localparam int CTL_PS_LO = 4;
    localparam int CTL_WIDE  = 7;
    localparam logic [7:0] CTL_WMASK = 8'hBF;

    // interrupt register field positions
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_EN   = 1;

    // compare config register field positions
    localparam int CFG_ADC_EN = 4;

    localparam logic [7:0]  CTL_RST   = 8'h00;
    localparam logic [3:0]  MODE_SPECIAL_EVENT = 4'hB;
    localparam logic [15:0] CMP_RST   = 16'hFFFF;
    localparam logic [1:0]  PS_RST    = 2'h0;

    // rsvd keeps the struct at eight bits so every field sits at its
    // register position; it is masked on write and always reads zero
    typedef struct packed {
        logic        wide;
        logic        rsvd;
        logic [1:0]  div_sel;
        logic        osc_en;
        logic        no_sync;
        logic        src_ext;
        logic        en;
    } stc_ctrl_t;

    typedef struct packed {
        logic        cnt_in;
        logic        osc_in;
        logic        special_evt;
        logic        adc_req;
    } stc_evt_t;

endpackage

/* logic/stc_timer.sv */
// file: 16-bit timer/counter with apb register access
`timescale 1ns/1ps
// Function
// - control bit 0 runs the counter when set; cleared after reset
// - control bits 5:4 prescale the input by 1, 2, 4 or 8
// - control bit 1 picks external pin when set, internal ref_clk otherwise
// - internal source advances once per instruction cycle after prescale
// - external source counts rising edges of pin or of the oscillator
// - control bit 2 bypasses the synchronizer for external source; ignored internally
// - control bit 3 starts the auxiliary oscillator
// - both oscillator pins become inputs while the oscillator runs
// - oscillator keeps running in sleep
// - count wraps FFFFh to 0000h and latches the overflow flag
// - irq output only while overflow irq enable is set; flag still latches
// - compare mode 1011 special event clears counter and requests conversion
// - special event clear never sets the overflow flag
// - special event clear assured only for internal or synchronized counting
// - counter write beats a coincident special event clear
// - compare pair acts as period under special event mode
// - control bit 7 selects atomic 16-bit access
// - wide mode: low byte read copies live high byte into buffer
// - wide mode: low byte write loads buffer into high byte too
// - wide mode: high-byte address touches only the buffer
// - low byte write clears prescaler; high byte write does not
// - control bit 6 reads zero and ignores writes
module stc_timer (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_clock_pin,
    input  wire logic        osc_input_pin,
    input  wire logic        cpu_sleep,
    input  wire logic [1:0]  port_c_direction,
    output logic      [1:0]  osc_pin_dir,
    output logic             osc_run,
    output logic             irq,
    output logic             adc_start,
    output logic      [15:0] count_value
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    stc_pkg::stc_ctrl_t ctrl_r;
    logic [15:0] cnt_r;
    logic [7:0]  hi_buf_r;
    logic        flag_r;
    logic        irq_en_r;
    logic [15:0] cmp_r;
    logic [3:0]  cmp_mode_r;
    logic        adc_en_r;
    logic [2:0]  ps_r;
    logic        q_r;
    logic        sync1_r;
    logic        sync2_r;
    logic        sync2_d_r;
    logic        raw_d_r;
    logic        adc_r;
    logic [31:0] prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; slave answers in the access cycle, no wait states

    logic acc;
    logic wr;
    logic rd;
    logic hit;
    assign acc = psel && penable;
    assign wr  = acc && pwrite && pstrb[0];
    assign rd  = acc && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        if (paddr == stc_pkg::ADDR_CTRL || paddr == stc_pkg::ADDR_CNT_LO ||
            paddr == stc_pkg::ADDR_CNT_HI || paddr == stc_pkg::ADDR_IRQ ||
            paddr == stc_pkg::ADDR_CMP_LO || paddr == stc_pkg::ADDR_CMP_HI ||
            paddr == stc_pkg::ADDR_CMP_CFG) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end
    assign pslverr = acc && !hit;

    logic wr_ctl;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    assign wr_ctl = wr && paddr == stc_pkg::ADDR_CTRL;
    assign wr_lo  = wr && paddr == stc_pkg::ADDR_CNT_LO;
    assign wr_hi  = wr && paddr == stc_pkg::ADDR_CNT_HI;
    assign rd_lo  = rd && paddr == stc_pkg::ADDR_CNT_LO;

    ////////////////////////////////////////////////////////////////////////
    // clock selection, prescaler and synchronizer

    logic src_raw;
    logic raw_rise;
    logic ps_tick;
    logic q_rise;
    logic tick;
    // oscillator output overrides the pin when enabled
    assign src_raw = ctrl_r.osc_en ? osc_input_pin : ext_clock_pin;
    assign raw_rise = src_raw && !raw_d_r;

    // internal source counts every ref_clk cycle taken as one instruction
    // cycle of this block; external edges reach a rising-edge detector
    assign ps_tick = ctrl_r.src_ext ? raw_rise : 1'b1;

    // prescaler toggles q_r; each of its edges, rising or falling, is one divided clock
    logic [2:0] ps_mask;
    always_comb begin
        case (ctrl_r.div_sel)
            2'b11:   ps_mask = 3'h7;
            2'b10:   ps_mask = 3'h3;
            2'b01:   ps_mask = 3'h1;
            default: ps_mask = 3'h0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || wr_lo) begin
            ps_r <= 3'h0;
        end else if (ctrl_r.en && ps_tick) begin
            ps_r <= (ps_r & ps_mask) == ps_mask ? 3'h0 : ps_r + 3'h1;
        end
    end
    logic ps_out;
    assign ps_out = ctrl_r.en && ps_tick && ((ps_r & ps_mask) == ps_mask);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            raw_d_r   <= 1'b0;
            q_r       <= 1'b0;
            sync1_r   <= 1'b0;
            sync2_r   <= 1'b0;
            sync2_d_r <= 1'b0;
        end else begin
            raw_d_r   <= src_raw;
            q_r       <= ps_out ? ~q_r : q_r;
            sync1_r   <= q_r;
            sync2_r   <= sync1_r;
            sync2_d_r <= sync2_r;
        end
    end

    // unsynchronized path uses the prescaler pulse directly; a true
    // asynchronous counter would need its own clock domain
    always_comb begin
        if (!ctrl_r.src_ext || ctrl_r.no_sync) begin
            tick = ps_out;
        end else begin
            tick = sync2_r != sync2_d_r;
        end
    end
    assign q_rise = tick;

    ////////////////////////////////////////////////////////////////////////
    // counter, special event and overflow

    logic special;
    logic evt_ok;
    logic wrap;
    assign special = cmp_mode_r == stc_pkg::MODE_SPECIAL_EVENT &&
                     cnt_r == cmp_r && ctrl_r.en;
    // clear is honoured only when the count path is synchronous
    assign evt_ok = !ctrl_r.src_ext || !ctrl_r.no_sync;
    assign wrap = q_rise && cnt_r == 16'hFFFF;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= 16'h0000;
        end else if (wr_lo) begin
            cnt_r[7:0] <= pwdata[7:0];
            if (ctrl_r.wide) begin
                cnt_r[15:8] <= hi_buf_r;
            end
        end else if (wr_hi && !ctrl_r.wide) begin
            cnt_r[15:8] <= pwdata[7:0];
        end else if (special && evt_ok) begin
            cnt_r <= 16'h0000;
        end else if (q_rise) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hi_buf_r <= 8'h00;
        end else if (rd_lo && ctrl_r.wide) begin
            hi_buf_r <= cnt_r[15:8];
        end else if (wr_hi && ctrl_r.wide) begin
            hi_buf_r <= pwdata[7:0];
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_r <= 1'b0;
        end else if (wrap && !(special && evt_ok) && !wr_lo) begin
            flag_r <= 1'b1;
        end else if (wr && paddr == stc_pkg::ADDR_IRQ &&
                     !pwdata[stc_pkg::IRQ_FLAG]) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            adc_r <= 1'b0;
        end else begin
            adc_r <= special && evt_ok && adc_en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_r <= stc_pkg::CTL_RST;
        end else if (wr_ctl) begin
            ctrl_r <= pwdata[7:0] & stc_pkg::CTL_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_en_r   <= 1'b0;
            cmp_r      <= stc_pkg::CMP_RST;
            cmp_mode_r <= 4'h0;
            adc_en_r   <= 1'b0;
        end else if (wr) begin
            if (paddr == stc_pkg::ADDR_IRQ) begin
                irq_en_r <= pwdata[stc_pkg::IRQ_EN];
            end else if (paddr == stc_pkg::ADDR_CMP_LO) begin
                cmp_r[7:0] <= pwdata[7:0];
            end else if (paddr == stc_pkg::ADDR_CMP_HI) begin
                cmp_r[15:8] <= pwdata[7:0];
            end else if (paddr == stc_pkg::ADDR_CMP_CFG) begin
                cmp_mode_r <= pwdata[3:0];
                adc_en_r   <= pwdata[stc_pkg::CFG_ADC_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, combinational in the access cycle; the registered prdata_r copy is unused

    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (paddr == stc_pkg::ADDR_CTRL) begin
            rd_nxt[7:0] = ctrl_r;
        end else if (paddr == stc_pkg::ADDR_CNT_LO) begin
            rd_nxt[7:0] = cnt_r[7:0];
        end else if (paddr == stc_pkg::ADDR_CNT_HI) begin
            rd_nxt[7:0] = ctrl_r.wide ? hi_buf_r : cnt_r[15:8];
        end else if (paddr == stc_pkg::ADDR_IRQ) begin
            rd_nxt[1:0] = {irq_en_r, flag_r};
        end else if (paddr == stc_pkg::ADDR_CMP_LO) begin
            rd_nxt[7:0] = cmp_r[7:0];
        end else if (paddr == stc_pkg::ADDR_CMP_HI) begin
            rd_nxt[7:0] = cmp_r[15:8];
        end else if (paddr == stc_pkg::ADDR_CMP_CFG) begin
            rd_nxt[4:0] = {adc_en_r, cmp_mode_r};
        end
    end
    // combinational read so data is valid in the one access cycle
    assign prdata = rd ? rd_nxt : 32'h0000_0000;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd) begin
            prdata_r <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // oscillator run request ignores sleep so counting continues
    assign osc_run = ctrl_r.osc_en;
    // 1 = input; pins forced to input while oscillator enabled
    assign osc_pin_dir = ctrl_r.osc_en ? 2'b11 : port_c_direction;
    assign irq = flag_r && irq_en_r;
    assign adc_start = adc_r;
    assign count_value = cnt_r;

    logic unused;
    assign unused = cpu_sleep ^ (^prdata_r);

endmodule

/* dv/stc_ext_src.sv */
// partner model: external count clock pin and low-power oscillator
`timescale 1ns/1ps
module stc_ext_src (
    input  wire logic ref_clk,
    input  wire logic osc_run,
    output logic      ext_clock_pin,
    output logic      osc_input_pin
);
    logic [2:0] div_r = 3'h0;
    initial ext_clock_pin = 1'b0;
    initial osc_input_pin = 1'b0;
    // pin stands low between bursts so no stray edge is counted
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge ref_clk);
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_clock_pin <= 1'b0;
        end
    endtask
    // sleep is not an input: the crystal runs whenever enabled
    always @(posedge ref_clk) begin
        div_r <= div_r + 3'h1;
        if (osc_run && div_r == 3'h7) osc_input_pin <= ~osc_input_pin;
    end
endmodule

/* dv/stc_timer_asserts.sv */
// checker: port-level properties of the timer, bound to its top module
`timescale 1ns/1ps
module stc_timer_asserts (
    input logic        ref_clk,
    input logic        sys_rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pslverr,
    input logic [1:0]  port_c_direction,
    input logic [1:0]  osc_pin_dir,
    input logic        osc_run,
    input logic        irq,
    input logic        adc_start,
    input logic [15:0] count_value
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic acc;
    logic wacc;
    assign acc = psel && penable;
    assign wacc = acc && pwrite && pstrb[0];
    bad_addr_a: assert property (acc && paddr > stc_pkg::ADDR_CMP_CFG
        |-> pslverr) else $error("no error on unmapped address");
    pin_dir_a: assert property (osc_pin_dir ==
        (osc_run ? 2'b11 : port_c_direction)) else $error("pin direction");
    bit6_zero_a: assert property (acc && !pwrite &&
        paddr == stc_pkg::ADDR_CTRL |-> !prdata[6]) else $error("bit6 set");
    osc_follow_a: assert property (wacc && paddr == stc_pkg::ADDR_CTRL
        |=> osc_run == $past(pwdata[3])) else $error("osc enable lost");
    rst_clear_a: assert property ($fell(sys_rst) |->
        count_value == 16'h0000 && !osc_run && !irq) else $error("reset");
    wrap_zero_a: assert property (count_value == 16'hFFFF && !wacc
        |=> count_value inside {16'hFFFF, 16'h0000}) else $error("wrap");
    one_step_a: assert property (!wacc |=> count_value == 16'h0000 ||
        16'(count_value - $past(count_value)) <= 16'h0001)
        else $error("count jumped");
    irq_mask_a: assert property (wacc && paddr == stc_pkg::ADDR_IRQ &&
        !pwdata[1] |=> !irq) else $error("irq not masked");
    adc_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("adc start too long");
    cover property (adc_start);
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule
bind stc_timer stc_timer_asserts stc_timer_asserts_i (.*);

/* dv/stc_timer_tb_top.sv */
// testbench: apb register and counting scenarios for the timer
`timescale 1ns/1ps
module stc_timer_tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        cpu_sleep = 1'b1;
    logic [1:0]  port_c_direction = 2'h1;
    logic [31:0] prdata, rd_d;
    logic [15:0] count_value, c0;
    logic [1:0]  osc_pin_dir;
    logic        pready, pslverr, osc_run, irq, adc_start, rd_err;
    logic        ext_clock_pin, osc_input_pin;
    int          error_cnt = 0;
    int          compares = 0;
    int          n;
    always #10 ref_clk = ~ref_clk;
    stc_timer   stc_timer_i (.*);
    stc_ext_src stc_ext_src_i (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            finish_test();
        end
        rd_d = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, string nm);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd_d);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk("pin dir", 2'h1, osc_pin_dir);
        rd(stc_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        wr(stc_pkg::ADDR_CTRL, 8'hFF);
        rd(stc_pkg::ADDR_CTRL, 8'hBF, "ctrl");
        chk("osc pin dir", 2'h3, osc_pin_dir);
        chk("osc run", 1'b1, osc_run);
        xfer(1'b0, 12'h01C, 32'h0000_0000);
        chk("slverr", 1'b1, rd_err);
        // last pass disables: the count must then hold
        for (int s = 0; s < 5; s++) begin
            wr(stc_pkg::ADDR_CTRL, (s == 4) ? 0 : (s << 4) | 1);
            repeat (8) @(negedge ref_clk);
            c0 = count_value;
            repeat (24) @(negedge ref_clk);
            chk("ticks", (s == 4) ? 0 : 24 >> s, 16'(count_value - c0));
        end
        for (int i = 0; i < 2; i++) begin
            wr(stc_pkg::ADDR_CTRL, 3 | (i << 2));
            repeat (8) @(negedge ref_clk);
            c0 = count_value;
            stc_ext_src_i.pulse(3 + i);
            repeat (8) @(negedge ref_clk);
            chk("ext edges", 3 + i, 16'(count_value - c0));
        end
        wr(stc_pkg::ADDR_CTRL, 8'h80);
        wr(stc_pkg::ADDR_CNT_HI, 8'h12);
        wr(stc_pkg::ADDR_CNT_LO, 8'h34);
        chk("wide write", 16'h1234, count_value);
        wr(stc_pkg::ADDR_CNT_HI, 8'h56);
        chk("live high", 8'h12, count_value[15:8]);
        rd(stc_pkg::ADDR_CNT_HI, 8'h56, "buffer");
        rd(stc_pkg::ADDR_CNT_LO, 8'h34, "low");
        rd(stc_pkg::ADDR_CNT_HI, 8'h12, "buffer copy");
        wr(stc_pkg::ADDR_CTRL, 8'h00);
        wr(stc_pkg::ADDR_CNT_HI, 8'hFF);
        chk("byte high", 16'hFF34, count_value);
        wr(stc_pkg::ADDR_CNT_LO, 8'hFE);
        wr(stc_pkg::ADDR_IRQ, 8'h02);
        wr(stc_pkg::ADDR_CTRL, 8'h01);
        repeat (6) @(negedge ref_clk);
        chk("irq", 1'b1, irq);
        rd(stc_pkg::ADDR_IRQ, 8'h03, "flag");
        wr(stc_pkg::ADDR_IRQ, 8'h01);
        chk("irq masked", 1'b0, irq);
        rd(stc_pkg::ADDR_IRQ, 8'h01, "flag kept");
        wr(stc_pkg::ADDR_IRQ, 8'h00);
        chk("irq off", 1'b0, irq);
        wr(stc_pkg::ADDR_CTRL, 8'h00);
        wr(stc_pkg::ADDR_CNT_HI, 8'h00);
        wr(stc_pkg::ADDR_CNT_LO, 8'h00);
        wr(stc_pkg::ADDR_CMP_LO, 8'h05);
        wr(stc_pkg::ADDR_CMP_HI, 8'h00);
        wr(stc_pkg::ADDR_CMP_CFG, 8'h1B);
        wr(stc_pkg::ADDR_CTRL, 8'h01);
        repeat (8) @(negedge ref_clk);
        n = 0;
        c0 = 16'h0000;
        repeat (24) begin
            @(negedge ref_clk);
            n += adc_start;
            if (count_value > c0) c0 = count_value;
        end
        chk("adc pulses", 4, n);
        chk("period top", 16'h0005, c0);
        // a special event clear at FFFFh must not look like an overflow
        wr(stc_pkg::ADDR_CTRL, 8'h00);
        wr(stc_pkg::ADDR_CMP_LO, 8'hFF);
        wr(stc_pkg::ADDR_CMP_HI, 8'hFF);
        wr(stc_pkg::ADDR_CNT_HI, 8'hFF);
        wr(stc_pkg::ADDR_CNT_LO, 8'hF0);
        wr(stc_pkg::ADDR_CTRL, 8'h01);
        repeat (24) @(negedge ref_clk);
        chk("cleared at top", 1'b1, count_value < 16'h0020);
        rd(stc_pkg::ADDR_IRQ, 8'h00, "no flag");
        finish_test();
    end
endmodule
